// [boot_loader_regs.vh]
`ifndef BOOT_LOADER_REGS_VH
`define BOOT_LOADER_REGS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_FREQ_HZ 100000000
`define STRAP_SETTLE_US 1000
`define STRAP_SETTLE_CYCLES ((`CLK_FREQ_HZ / 1000000) * `STRAP_SETTLE_US)

// ----------------------------------------
// event codes
// ----------------------------------------
`define EVT_NONE 16'h0000
`define EVT_ACQ_TIMING 16'h0D21
`define EVT_PRIMARY_FAIL 16'h0D01
`define EVT_FALLBACK_FAIL 16'h0D02
`define EVT_RECOVERY_BOOT 16'h0D10

// ----------------------------------------
// outcome encodings
// ----------------------------------------
`define OUTCOME_NONE 2'h0
`define OUTCOME_OK 2'h1
`define OUTCOME_FAIL 2'h2
`define OUTCOME_RECOVERY 2'h3

// ----------------------------------------
// image select
// ----------------------------------------
`define IMG_PRIMARY 2'h0
`define IMG_FALLBACK 2'h1
`define IMG_RECOVERY 2'h2

`endif

// [word_skid_buffer.v]
`timescale 1ns/1ps
// ----------------------------------------
// two-entry buffer
// ----------------------------------------
module word_skid_buffer (
    input wire mclk, // clock
    input wire rst_n, // synchronised reset, active low
    input wire flush, // drop contents
    input wire [31:0] in_data, // word in
    input wire in_valid, // word in valid
    output wire in_ready, // room for a word
    output wire [31:0] out_data, // word out
    output wire out_valid, // word out valid
    input wire out_ready // receiver accepts
);
    reg [31:0] mem_reg [0:1];
    reg wr_ptr_reg;
    reg rd_ptr_reg;
    reg [1:0] count_reg;
    reg room_reg;
    wire push;
    wire pop;

    // room is kept in a flop so the ready seen outside comes straight from a register
    assign in_ready = room_reg;
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
            room_reg <= 1'b1;
            mem_reg[0] <= 32'h0;
            mem_reg[1] <= 32'h0;
        end
        else if (flush)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
            room_reg <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            if (push && !pop)
            begin
                count_reg <= count_reg + 2'h1;
                room_reg <= (count_reg != 2'h1);
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 2'h1;
                room_reg <= 1'b1;
            end
        end
    end
endmodule // word_skid_buffer

// [boot_image_loader.v]
`timescale 1ns/1ps
`include "boot_loader_regs.vh"
module boot_image_loader (
    input wire mclk, // system clock, 100 MHz
    input wire rst_n, // power-on reset, active low
    input wire recovery_strap_pin, // strap pin level, asynchronous
    output reg strap_pullup_en, // internal pull-up enable for strap pin
    output reg fuse_start, // one-cycle request to process fuses
    input wire fuse_done, // fuse processing finished, same clock
    output reg load_start, // one-cycle request to load an image
    output reg [1:0] load_image_sel, // image being loaded
    output reg private_boot_strap, // route flash access to private interface
    input wire load_done, // image load finished, same clock
    input wire load_fail, // image load failed, valid with load_done
    input wire load_acq_timing, // failure was acquisition timing, with load_done
    input wire [31:0] img_data, // image word from flash
    input wire img_valid, // image word valid
    output wire img_ready, // loader can take a word
    output reg [31:0] sram_data, // image word to code sram
    output reg sram_valid, // sram word valid
    input wire sram_ready, // sram accepts word
    output reg boot_done, // loader has finished
    output reg [1:0] boot_outcome, // ok, fail or recovery
    output reg [15:0] event_code, // last event logged
    output reg event_valid // one-cycle pulse when event logged
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_PULLUP = 3'h0;
    localparam ST_FUSE = 3'h1;
    localparam ST_SETTLE = 3'h2;
    localparam ST_SAMPLE = 3'h3;
    localparam ST_LOAD = 3'h4;
    localparam ST_WAIT = 3'h5;
    localparam ST_OK = 3'h6;
    localparam ST_FAIL = 3'h7;
    localparam integer SETTLE_FULL = `STRAP_SETTLE_CYCLES;
    // 100000 cycles fits in 17 bits; the upper bits are cut on purpose
    localparam [16:0] SETTLE_CYCLES = SETTLE_FULL[16:0];

    reg rst_meta_reg;
    reg rst_sync_reg;
    wire srst_n;
    reg strap_meta_reg;
    reg strap_sync_reg;
    reg [2:0] state_reg;
    reg [16:0] settle_cnt_reg;
    reg fuse_busy_reg;
    wire buf_out_valid;
    wire [31:0] buf_out_data;
    wire out_free;

    // ----------------------------------------
    // reset release and pin sync
    // ----------------------------------------
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign srst_n = rst_sync_reg;

    always @(posedge mclk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            strap_meta_reg <= 1'b1;
            strap_sync_reg <= 1'b1;
        end
        else
        begin
            strap_meta_reg <= recovery_strap_pin;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // ----------------------------------------
    // image data path
    // ----------------------------------------
    // a stall on the sram side backs up into the flash stream, no word lost
    // words arrive whole, so the lane count of the flash read does not matter here
    assign out_free = !sram_valid || sram_ready;

    word_skid_buffer u_buf (
        .mclk(mclk),
        .rst_n(srst_n),
        .flush(load_start),
        .in_data(img_data),
        .in_valid(img_valid),
        .in_ready(img_ready),
        .out_data(buf_out_data),
        .out_valid(buf_out_valid),
        .out_ready(out_free)
    );

    always @(posedge mclk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            sram_valid <= 1'b0;
            sram_data <= 32'h0;
        end
        else if (out_free)
        begin
            sram_valid <= buf_out_valid;
            sram_data <= buf_out_data;
        end
    end

    // ----------------------------------------
    // boot sequencer
    // ----------------------------------------
    always @(posedge mclk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            state_reg <= ST_PULLUP;
            settle_cnt_reg <= 17'h0;
            fuse_busy_reg <= 1'b0;
            strap_pullup_en <= 1'b0;
            fuse_start <= 1'b0;
            load_start <= 1'b0;
            load_image_sel <= `IMG_PRIMARY;
            private_boot_strap <= 1'b0;
            boot_done <= 1'b0;
            boot_outcome <= `OUTCOME_NONE;
            event_code <= `EVT_NONE;
            event_valid <= 1'b0;
        end
        else
        begin
            fuse_start <= 1'b0;
            load_start <= 1'b0;
            event_valid <= 1'b0;
            if (state_reg != ST_PULLUP && settle_cnt_reg != SETTLE_CYCLES)
                settle_cnt_reg <= settle_cnt_reg + 17'h1;
            case (state_reg)
                ST_PULLUP:
                begin
                    strap_pullup_en <= 1'b1;
                    settle_cnt_reg <= 17'h0;
                    state_reg <= ST_FUSE;
                end
                ST_FUSE:
                begin
                    if (!fuse_busy_reg)
                    begin
                        fuse_start <= 1'b1;
                        fuse_busy_reg <= 1'b1;
                    end
                    else if (fuse_done)
                        state_reg <= ST_SETTLE;
                end
                ST_SETTLE:
                begin
                    // fuse time counts toward the settle time; sample only after both
                    if (settle_cnt_reg == SETTLE_CYCLES)
                        state_reg <= ST_SAMPLE;
                end
                ST_SAMPLE:
                begin
                    load_start <= 1'b1;
                    state_reg <= ST_WAIT;
                    if (!strap_sync_reg)
                    begin
                        private_boot_strap <= 1'b1;
                        load_image_sel <= `IMG_RECOVERY;
                        event_code <= `EVT_RECOVERY_BOOT;
                        event_valid <= 1'b1;
                    end
                    else
                        load_image_sel <= `IMG_PRIMARY;
                end
                ST_LOAD:
                begin
                    load_start <= 1'b1;
                    state_reg <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (load_done)
                    begin
                        if (!load_fail)
                            state_reg <= ST_OK;
                        else
                        begin
                            event_valid <= 1'b1;
                            if (load_acq_timing)
                                event_code <= `EVT_ACQ_TIMING;
                            else if (load_image_sel == `IMG_PRIMARY)
                                event_code <= `EVT_PRIMARY_FAIL;
                            else
                                event_code <= `EVT_FALLBACK_FAIL;
                            if (load_image_sel == `IMG_PRIMARY)
                            begin
                                load_image_sel <= `IMG_FALLBACK;
                                state_reg <= ST_LOAD;
                            end
                            else
                                state_reg <= ST_FAIL;
                        end
                    end
                end
                ST_OK:
                begin
                    boot_done <= 1'b1;
                    boot_outcome <= private_boot_strap ? `OUTCOME_RECOVERY : `OUTCOME_OK;
                end
                ST_FAIL:
                begin
                    boot_done <= 1'b1;
                    boot_outcome <= `OUTCOME_FAIL;
                end
                default:
                    state_reg <= ST_PULLUP;
            endcase
        end
    end
endmodule // boot_image_loader

// [boot_loader_checker_properties.sv]
`timescale 1ns/1ps
`include "boot_loader_regs.vh"
module boot_loader_checker (
    input wire mclk, // clock
    input wire rst_n, // reset
    input wire strap_pullup_en, // pull-up
    input wire fuse_start, // fuse request
    input wire fuse_done, // fuse answer
    input wire load_start, // load request
    input wire [1:0] load_image_sel, // image
    input wire private_boot_strap, // recovery route
    input wire load_done, // load end
    input wire load_fail, // load bad
    input wire load_acq_timing, // timing fault
    input wire boot_done, // finished
    input wire [1:0] boot_outcome, // result
    input wire [15:0] event_code, // event
    input wire event_valid // event pulse
);
    reg fuse_ok_reg;
    // fuses only count once answered with the pull-up already on
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            fuse_ok_reg <= 1'b0;
        else if (fuse_done && strap_pullup_en)
            fuse_ok_reg <= 1'b1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_primary_fail; load_done && load_fail && load_image_sel == `IMG_PRIMARY && !private_boot_strap; endsequence
    sequence s_fallback_start; load_start && load_image_sel == `IMG_FALLBACK; endsequence
    property p_pullup_first; fuse_start || load_start |-> strap_pullup_en; endproperty
    a_pullup_first: assert property (p_pullup_first) else $error("request before pull-up");
    property p_fuse_first; load_start |-> fuse_ok_reg; endproperty
    a_fuse_first: assert property (p_fuse_first) else $error("load before fuses done");
    property p_recovery_route; load_start && load_image_sel == `IMG_RECOVERY |-> private_boot_strap; endproperty
    a_recovery_route: assert property (p_recovery_route) else $error("recovery not routed");
    property p_fallback; s_primary_fail |-> ##2 s_fallback_start; endproperty
    a_fallback: assert property (p_fallback) else $error("no fallback load");
    sequence s_last_fail; load_done && load_fail && load_image_sel != `IMG_PRIMARY; endsequence
    property p_fail_exit; s_last_fail |-> ##[1:8] (boot_done && boot_outcome == `OUTCOME_FAIL); endproperty
    a_fail_exit: assert property (p_fail_exit) else $error("no failure exit");
    property p_acq_event; load_done && load_fail && load_acq_timing |=> event_valid && event_code == `EVT_ACQ_TIMING;
    endproperty
    a_acq_event: assert property (p_acq_event) else $error("timing event missing");
    property p_ok_outcome; load_done && !load_fail
        |-> ##[1:8] (boot_done && boot_outcome == (private_boot_strap ? `OUTCOME_RECOVERY : `OUTCOME_OK)); endproperty
    a_ok_outcome: assert property (p_ok_outcome) else $error("success not shown");
    property p_done_held; boot_done |=> boot_done && $stable(boot_outcome); endproperty
    a_done_held: assert property (p_done_held) else $error("outcome not held");
endmodule // boot_loader_checker
bind boot_image_loader boot_loader_checker chk (.*);

// [flash_image_model.sv]
`timescale 1ns/1ps
module flash_image_model (
    input wire mclk, // clock
    input wire rst_n, // reset
    input wire load_start, // begin image
    input wire [1:0] load_image_sel, // image
    input wire [2:0] fail_map, // images that fail
    input wire [2:0] acq_map, // timing faults
    output wire [31:0] img_data, // word
    output reg img_valid, // word valid
    input wire img_ready, // word taken
    output reg load_done, // image end
    output wire load_fail, // image bad
    output wire load_acq_timing // timing cause
);
    reg [31:0] word_reg;
    reg [5:0] left_reg;
    reg [4:0] hold_reg;
    wire take = img_valid && img_ready;
    // released lines show the inverse so a stale word cannot pass
    assign img_data = img_valid ? word_reg : ~word_reg;
    assign load_fail = fail_map[load_image_sel];
    assign load_acq_timing = acq_map[load_image_sel];
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_reg <= 32'h0;
            img_valid <= 1'b0;
            left_reg <= 6'h00;
            hold_reg <= 5'h00;
            load_done <= 1'b0;
        end
        else
        begin
            load_done <= hold_reg == 5'h01;
            if (hold_reg != 5'h00)
                hold_reg <= hold_reg - 5'h01;
            if (load_start)
                left_reg <= 6'h10;
            else if (take)
            begin
                word_reg <= word_reg + 32'h1;
                left_reg <= left_reg - 6'h01;
                hold_reg <= 5'h10;
            end
            img_valid <= left_reg != 6'h00 && !(take && left_reg == 6'h01);
        end
    end
endmodule // flash_image_model

// [boot_image_loader_test.sv]
`timescale 1ns/1ps
`include "boot_loader_regs.vh"
module boot_image_loader_test;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg recovery_strap_pin = 1'b1;
    reg fuse_done = 1'b0;
    reg sram_ready = 1'b0;
    reg [2:0] fail_map = 3'h0;
    reg [2:0] acq_map = 3'h0;
    wire strap_pullup_en, fuse_start, load_start, private_boot_strap, load_done, load_fail, load_acq_timing;
    wire img_valid, img_ready, sram_valid, boot_done, event_valid;
    wire [1:0] load_image_sel;
    wire [1:0] boot_outcome;
    wire [31:0] img_data;
    wire [31:0] sram_data;
    wire [15:0] event_code;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int t_pull;
    int t_load;
    logic [31:0] rx[$];
    logic [15:0] evts[$];
    logic [1:0] sels[$];
    always #5 mclk = ~mclk;
    boot_image_loader dut (.*);
    flash_image_model flash (.*);
    // the sram stalls 4 cycles in 16 so the buffer fills and refuses
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        sram_ready <= cyc[3:2] != 2'h0;
        fuse_done <= fuse_start;
        if (sram_valid && sram_ready)
            rx.push_back(sram_data);
        if (event_valid)
            evts.push_back(event_code);
        if (load_start)
            sels.push_back(load_image_sel);
        if (!rst_n)
        begin
            t_pull <= 0;
            t_load <= 0;
        end
        else
        begin
            if (strap_pullup_en && t_pull == 0)
                t_pull <= cyc;
            if (load_start && t_load == 0)
                t_load <= cyc;
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic boot(input logic pin, input logic [2:0] fm, input logic [2:0] am);
        int n;
        rst_n <= 1'b0;
        recovery_strap_pin <= pin;
        fail_map <= fm;
        acq_map <= am;
        rx.delete();
        evts.delete();
        sels.delete();
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (n = 0; n < 120000 && boot_done !== 1'b1; n++)
            @(posedge mclk);
        repeat (4) @(posedge mclk);
        check("settle wait", t_load - t_pull >= `STRAP_SETTLE_CYCLES, 1);
        check("word count", rx.size(), 16 * sels.size());
        foreach (rx[i])
            check("word", rx[i], i);
    endtask
    task automatic t_fallback;
        boot(1'b1, 3'h1, 3'h1);
        check("image count", sels.size(), 2);
        check("second image", sels[1], `IMG_FALLBACK);
        check("timing event", evts[0], `EVT_ACQ_TIMING);
        check("outcome", boot_outcome, `OUTCOME_OK);
        $display("test fallback done");
    endtask
    task automatic t_double_fail;
        boot(1'b1, 3'h3, 3'h0);
        check("image count", sels.size(), 2);
        check("outcome", boot_outcome, `OUTCOME_FAIL);
        check("primary event", evts[0], `EVT_PRIMARY_FAIL);
        $display("test double_fail done");
    endtask
    task automatic t_recovery;
        boot(1'b0, 3'h0, 3'h0);
        check("image", sels[0], `IMG_RECOVERY);
        check("private route", private_boot_strap, 1);
        check("outcome", boot_outcome, `OUTCOME_RECOVERY);
        $display("test recovery done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        @(posedge mclk);
        t_fallback();
        t_double_fail();
        t_recovery();
        end_of_test();
    end
    // three boots of about 100k cycles each, with margin
    initial
    begin
        #4000000;
        n_errors++;
        end_of_test();
    end
endmodule // boot_image_loader_test
